//--- dmtc_timer.sv
// dual mode timer with capture: prescaler, two counter bytes, AXI4-Lite slave
// assumes oscillator inputs are synchronous levels; one clock, clock enable
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "dmtc_params.svh"

module dmtc_timer (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // count sources
    input wire logic rc_osc_i,
    input wire logic crystal_source_a_i,
    input wire logic crystal_source_b_i,
    // axi4-lite write
    input wire logic [`DMTC_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [`DMTC_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // interrupt requests
    output logic irq_low_o,
    output logic irq_high_o
);

    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0] match_low_q;
    logic [7:0] match_high_q;
    dmtc_pkg::dmtc_control_type ctrl_q, ctrl_d;
    dmtc_pkg::dmtc_divider_mode_type divm_q;
    logic [4:0] pre_q, pre_d;
    logic [7:0] low_q, low_d, high_q, high_d;
    logic [7:0] buf_low_q, buf_low_d, buf_high_q, buf_high_d;
    logic [7:0] cap_low_q, cap_high_q;
    logic src_prev_q;
    logic aw_full_q, w_full_q;
    logic [`DMTC_ADDR_W-3:0] aw_idx_q;
    logic [7:0] wdata_q;
    logic wstrb_q;

    // ****************************************
    // bus decode
    // ****************************************
    wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
    wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
    wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
    wire commit = aw_full_q & w_full_q & ~s_axi_bvalid_o;
    wire wr_ok = commit & wstrb_q;
    wire wr_mlow = wr_ok && aw_idx_q == `DMTC_IDX_MATCH_LOW;
    wire wr_mhigh = wr_ok && aw_idx_q == `DMTC_IDX_MATCH_HIGH;
    wire wr_ctrl = wr_ok && aw_idx_q == `DMTC_IDX_CONTROL;
    wire wr_divm = wr_ok && aw_idx_q == `DMTC_IDX_DIVIDER_MODE;
    wire aw_mapped = aw_idx_q >= `DMTC_IDX_MATCH_LOW && aw_idx_q <= `DMTC_IDX_DIVIDER_MODE;
    wire [`DMTC_ADDR_W-3:0] ar_idx = s_axi_araddr_i[`DMTC_ADDR_W-1:2];
    wire ar_mapped = ar_idx >= `DMTC_IDX_MATCH_LOW && ar_idx <= `DMTC_IDX_DIVIDER_MODE;
    dmtc_pkg::dmtc_control_type wr_ctrl_val;
    assign wr_ctrl_val = dmtc_pkg::dmtc_control_type'(wdata_q);

    wire [7:0] rd_low = divm_q.capture_read_select ? cap_low_q : match_low_q;
    wire [7:0] rd_high = divm_q.capture_read_select ? cap_high_q : match_high_q;
    wire [7:0] rd_byte = (ar_idx == `DMTC_IDX_MATCH_LOW) ? rd_low :
                         (ar_idx == `DMTC_IDX_MATCH_HIGH) ? rd_high :
                         (ar_idx == `DMTC_IDX_CONTROL) ? ctrl_q : divm_q;

    // ****************************************
    // count source and prescaler
    // ****************************************
    wire run = ctrl_q.run;
    wire split = divm_q.split_byte_mode;
    wire src_lvl = (ctrl_q.count_source_select == dmtc_pkg::SRC_RC_OSC) ? rc_osc_i :
                   (ctrl_q.count_source_select == dmtc_pkg::SRC_CRYSTAL_A) ? crystal_source_a_i :
                   crystal_source_b_i;
    wire src_tick = (ctrl_q.count_source_select == dmtc_pkg::SRC_SYSTEM) |
                    (src_lvl & ~src_prev_q);
    wire pre_hit = run & src_tick & (pre_q == divm_q.divider_limit);
    wire high_run = split ? ctrl_q.high_count_enable : run;
    wire full_hit = pre_hit & ({high_q, low_q} == {buf_high_q, buf_low_q});
    wire low_hit = split ? (pre_hit & (low_q == buf_low_q)) : full_hit;
    wire high_hit = split ? (high_run & (high_q == buf_high_q)) : full_hit;
    wire low_wrap = pre_hit & (low_q == 8'hFF);

    always_comb begin
        pre_d = pre_q;
        if (!run) begin
            pre_d = 5'h00;
        end else if (pre_hit) begin
            pre_d = 5'h00;
        end else if (src_tick) begin
            pre_d = pre_q + 5'h01;
        end
    end

    // ****************************************
    // counter bytes
    // ****************************************
    always_comb begin
        low_d = low_q;
        if (!run || low_hit) begin
            low_d = 8'h00;
        end else if (pre_hit) begin
            low_d = low_q + 8'h01;
        end
    end

    always_comb begin
        high_d = high_q;
        if (!high_run || high_hit) begin
            high_d = 8'h00;
        end else if (split || low_wrap) begin
            high_d = high_q + 8'h01;
        end
    end

    assign buf_low_d = (!run || low_q == 8'h00) ? match_low_q : buf_low_q;
    assign buf_high_d = (!high_run || high_q == 8'h00) ? match_high_q : buf_high_q;

    // ****************************************
    // control register and flags
    // ****************************************
    always_comb begin
        ctrl_d = wr_ctrl ? wr_ctrl_val : ctrl_q;
        // low flag set on match, high flag only on split-mode high match; set wins over clear
        if (low_hit) begin
            ctrl_d.low_match_flag = 1'b1;
        end
        if (split && high_hit) begin
            ctrl_d.high_match_flag = 1'b1;
        end
    end

    wire high_rise = ctrl_d.high_match_flag & ~ctrl_q.high_match_flag;
    wire low_rise = ctrl_d.low_match_flag & ~ctrl_q.low_match_flag;
    wire cap_low_en = divm_q.capture_enable & high_rise;
    wire cap_high_en = divm_q.capture_enable & (split ? low_rise : high_rise);

    // ****************************************
    // timer state
    // ****************************************
    // zero reset, timer stopped
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_low_q <= `DMTC_RST_MATCH_LOW;
            match_high_q <= `DMTC_RST_MATCH_HIGH;
            ctrl_q <= `DMTC_RST_CONTROL;
            divm_q <= `DMTC_RST_DIVIDER_MODE;
            pre_q <= 5'h00;
            low_q <= 8'h00;
            high_q <= 8'h00;
            buf_low_q <= 8'h00;
            buf_high_q <= 8'h00;
            cap_low_q <= 8'h00;
            cap_high_q <= 8'h00;
            src_prev_q <= 1'b0;
            irq_low_o <= 1'b0;
            irq_high_o <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_mlow) match_low_q <= wdata_q;
            if (wr_mhigh) match_high_q <= wdata_q;
            if (wr_divm) divm_q <= wdata_q;
            ctrl_q <= ctrl_d;
            pre_q <= pre_d;
            low_q <= low_d;
            high_q <= high_d;
            buf_low_q <= buf_low_d;
            buf_high_q <= buf_high_d;
            if (cap_low_en) cap_low_q <= low_q;
            if (cap_high_en) cap_high_q <= high_q;
            src_prev_q <= src_lvl;
            irq_low_o <= ctrl_d.low_irq_enable & ctrl_d.low_match_flag;
            irq_high_o <= ctrl_d.high_irq_enable & ctrl_d.high_match_flag;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_idx_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `DMTC_RESP_OKAY;
        end else if (clk_en_i) begin
            if (aw_hs) begin
                aw_idx_q <= s_axi_awaddr_i[`DMTC_ADDR_W-1:2];
                aw_full_q <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end else if (!aw_full_q && !s_axi_bvalid_o) begin
                s_axi_awready_o <= 1'b1;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb_q <= s_axi_wstrb_i[0];
                w_full_q <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end else if (!w_full_q && !s_axi_bvalid_o) begin
                s_axi_wready_o <= 1'b1;
            end
            if (commit) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= aw_mapped ? `DMTC_RESP_OKAY : `DMTC_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `DMTC_RESP_OKAY;
        end else if (clk_en_i) begin
            if (ar_hs) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= ar_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                s_axi_rresp_o <= ar_mapped ? `DMTC_RESP_OKAY : `DMTC_RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end else if (!s_axi_rvalid_o) begin
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    pre_clear_a: assert property (clk_en_i && !run |=> pre_q == 5'h00)
        else $error("prescaler not cleared while stopped");
    pre_wrap_a: assert property (clk_en_i && pre_hit |=> pre_q == 5'h00)
        else $error("prescaler not cleared on its match");
    low_step_a: assert property (clk_en_i && pre_hit && !low_hit |=> low_q == $past(low_q) + 8'h01)
        else $error("low byte did not advance on prescaler pulse");
    match_reset_a: assert property (clk_en_i && low_hit |=> low_q == 8'h00 && ctrl_q.low_match_flag)
        else $error("low match did not clear counter and set flag");
    high_stop_a: assert property (clk_en_i && !high_run |=> high_q == 8'h00)
        else $error("high byte runs while its run source is 0");
    split_count_a: assert property (clk_en_i && split && high_run && !high_hit
        |=> high_q == $past(high_q) + 8'h01)
        else $error("split high byte not counting system clocks");
    buf_track_a: assert property (clk_en_i && !run |=> buf_low_q == $past(match_low_q))
        else $error("low buffer not tracking while stopped");
    cap_low_a: assert property (clk_en_i && cap_low_en |=> cap_low_q == $past(low_q))
        else $error("low capture missed high flag rise");
    flag_hold_a: assert property (clk_en_i && ctrl_q.low_match_flag && !wr_ctrl
        |=> ctrl_q.low_match_flag)
        else $error("low flag dropped without a write");
    irq_req_a: assert property (clk_en_i && ctrl_q.low_irq_enable
        && ctrl_q.low_match_flag && !wr_ctrl |=> irq_low_o)
        else $error("low interrupt request missing");
    read_sel_a: assert property (clk_en_i && ar_hs && ar_idx == `DMTC_IDX_MATCH_LOW
        && divm_q.capture_read_select |=> s_axi_rdata_o[7:0] == $past(cap_low_q))
        else $error("capture read select not honoured");
    cap_high_a: assert property (clk_en_i && cap_high_en |=> cap_high_q == $past(high_q))
        else $error("high capture missed its trigger");
    cap_both_a: assert property (clk_en_i && !split && wr_ctrl
        && wr_ctrl_val.high_match_flag && !ctrl_q.high_match_flag && divm_q.capture_enable
        |=> cap_low_q == $past(low_q) && cap_high_q == $past(high_q))
        else $error("software flag set did not capture both bytes");
    full_clear_a: assert property (clk_en_i && !split && full_hit
        |=> low_q == 8'h00 && high_q == 8'h00)
        else $error("sixteen-bit match did not clear both bytes");
    split_high_a: assert property (clk_en_i && split && high_hit
        |=> high_q == 8'h00 && ctrl_q.high_match_flag)
        else $error("split high byte did not clear and flag on match");
    buf_hold_a: assert property (clk_en_i && run && low_q != 8'h00
        |=> buf_low_q == $past(buf_low_q))
        else $error("low buffer reloaded away from counter zero");
    src_system_a: assert property (clk_en_i && run && !pre_hit
        && ctrl_q.count_source_select == dmtc_pkg::SRC_SYSTEM
        |=> pre_q == $past(pre_q) + 5'h01)
        else $error("system clock source did not tick the prescaler");
    irq_high_a: assert property (clk_en_i && ctrl_q.high_irq_enable
        && ctrl_q.high_match_flag && !wr_ctrl |=> irq_high_o)
        else $error("high interrupt request missing");
    low_split_a: assert property (clk_en_i && split && pre_hit && low_q == buf_low_q
        |=> low_q == 8'h00 && ctrl_q.low_match_flag)
        else $error("split low byte did not match on its own buffer");
    ctrl_write_a: assert property (clk_en_i && wr_ctrl && !low_hit && !(split && high_hit)
        |=> ctrl_q == $past(wr_ctrl_val))
        else $error("control write did not land");

    full_match_c: cover property (!split && full_hit && run);
    split_match_c: cover property (split && high_hit);
    capture_c: cover property (cap_high_en && cap_low_en);
    slow_src_c: cover property (pre_hit && ctrl_q.count_source_select != dmtc_pkg::SRC_SYSTEM);
    freeze_c: cover property (!clk_en_i && run);

endmodule

//--- dmtc_params.svh
// constants for the dual mode timer with capture
// assumes a 32-bit AXI4-Lite register bus and byte-wide registers
`ifndef DMTC_PARAMS_SVH
`define DMTC_PARAMS_SVH

// ****************************************
// register indices, byte address = 4 x index
// ****************************************
`define DMTC_IDX_MATCH_LOW 16'h7F14
`define DMTC_IDX_MATCH_HIGH 16'h7F15
`define DMTC_IDX_CONTROL 16'h7F16
`define DMTC_IDX_DIVIDER_MODE 16'h7F17

// ****************************************
// reset values
// ****************************************
`define DMTC_RST_MATCH_LOW 8'h00
`define DMTC_RST_MATCH_HIGH 8'h00
`define DMTC_RST_CONTROL 8'h00
`define DMTC_RST_DIVIDER_MODE 8'h00

// ****************************************
// bus answers
// ****************************************
`define DMTC_RESP_OKAY 2'h0
`define DMTC_RESP_SLVERR 2'h2
`define DMTC_ADDR_W 18

`endif

//--- dmtc_pkg.sv
// types for the dual mode timer with capture
// assumes dmtc_params.svh holds the numeric constants
package dmtc_pkg;

    // ****************************************
    // count source encoding
    // ****************************************
    typedef enum logic [1:0] {
        SRC_SYSTEM,
        SRC_RC_OSC,
        SRC_CRYSTAL_A,
        SRC_CRYSTAL_B
    } dmtc_source_type;

    // ****************************************
    // register layouts
    // ****************************************
    typedef struct packed {
        logic high_count_enable;
        logic high_match_flag;
        logic high_irq_enable;
        dmtc_source_type count_source_select;
        logic run;
        logic low_match_flag;
        logic low_irq_enable;
    } dmtc_control_type;

    typedef struct packed {
        logic capture_read_select;
        logic split_byte_mode;
        logic capture_enable;
        logic [4:0] divider_limit;
    } dmtc_divider_mode_type;

endpackage

//--- dmtc_timer_tb_top.sv
// self-checking bench for the dual mode timer with capture
// assumes dmtc_timer and dmtc_params.svh; the bench drives every port
`include "dmtc_params.svh"

module dmtc_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals and tables
    // ****************************************
    typedef struct {
        logic [15:0] idx;
        logic [7:0] wd;
        logic [3:0] st;
        logic [31:0] rd;
        logic [1:0] rs;
    } dmtc_reg_row_type;
    typedef struct {
        logic [7:0] ctrl;
        logic [7:0] dm;
        logic [7:0] ml;
        logic [7:0] mh;
        logic hi;
        int exp;
    } dmtc_per_row_type;
    localparam logic [15:0] i_ml = `DMTC_IDX_MATCH_LOW;
    localparam logic [15:0] i_mh = `DMTC_IDX_MATCH_HIGH;
    localparam logic [15:0] i_ct = `DMTC_IDX_CONTROL;
    localparam logic [15:0] i_dm = `DMTC_IDX_DIVIDER_MODE;
    localparam logic [1:0] ok = `DMTC_RESP_OKAY;
    logic clk, arst_n, clk_en, rc_osc, osc_a, osc_b;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq_l, irq_h;
    int errors, n_compared, cyc, t0;
    dmtc_reg_row_type rows [6] = '{
        '{i_ml, 8'hA5, 4'h1, 32'h000000A5, ok},
        '{i_mh, 8'h5A, 4'h1, 32'h0000005A, ok},
        '{i_ct, 8'h39, 4'h1, 32'h00000039, ok},
        '{i_dm, 8'h3F, 4'h1, 32'h0000003F, ok},
        '{i_ml, 8'hC3, 4'h0, 32'h000000A5, ok},
        '{16'h7F18, 8'h77, 4'h1, 32'h00000000, `DMTC_RESP_SLVERR}};
    dmtc_per_row_type pers [6] = '{
        '{8'h05, 8'h03, 8'h09, 8'h00, 1'b0, 40},
        '{8'h0D, 8'h00, 8'h04, 8'h00, 1'b0, 40},
        '{8'h15, 8'h01, 8'h03, 8'h00, 1'b0, 48},
        '{8'h1D, 8'h00, 8'h02, 8'h00, 1'b0, 30},
        '{8'h05, 8'h00, 8'h03, 8'h01, 1'b0, 260},
        '{8'hA0, 8'h40, 8'h00, 8'h1F, 1'b1, 32}};

    dmtc_timer dmtc_timer_inst (
        .ref_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(clk_en), .rc_osc_i(rc_osc),
        .crystal_source_a_i(osc_a), .crystal_source_b_i(osc_b),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_low_o(irq_l),
        .irq_high_o(irq_h));

    // ****************************************
    // clock and slow count sources
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        rc_osc <= (cyc % 8) < 4;
        osc_a <= (cyc % 6) < 3;
        osc_b <= (cyc % 10) < 5;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
    endtask

    task automatic bus_wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        while (bvalid !== 1'b1) @(posedge clk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [15:0] idx);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_rise(input logic hi);
        logic prev, now;
        int n;
        prev = 1'b1;
        now = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            prev = now;
            now = hi ? irq_h : irq_l;
            n++;
        end while (!(prev === 1'b0 && now === 1'b1) && n < 2000);
        if (n >= 2000) errors++;
    endtask

    task automatic measure(input dmtc_per_row_type p);
        int t1;
        bus_wr(i_ct, 8'h00, 4'h1);
        bus_wr(i_ml, p.ml, 4'h1);
        bus_wr(i_mh, p.mh, 4'h1);
        bus_wr(i_dm, p.dm, 4'h1);
        bus_wr(i_ct, p.ctrl, 4'h1);
        wait_rise(p.hi);
        bus_rd(i_ct);
        check(rd & (p.hi ? 32'h40 : 32'h02), p.hi ? 32'h40 : 32'h02);
        bus_wr(i_ct, p.ctrl, 4'h1);
        wait_rise(p.hi);
        t1 = cyc;
        bus_wr(i_ct, p.ctrl, 4'h1);
        wait_rise(p.hi);
        check(32'(cyc - t1), 32'(p.exp));
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {arst_n, clk_en, awvalid, wvalid, bready, arvalid, rready} = 7'h20;
        {awaddr, araddr, wdata, wstrb, cyc, errors, n_compared} = '0;
        {rc_osc, osc_a, osc_b} = 3'h0;
        do_reset();
        foreach (rows[i]) begin
            bus_wr(rows[i].idx, rows[i].wd, rows[i].st);
            check(32'(resp), 32'(rows[i].rs));
            bus_rd(rows[i].idx);
            check(rd, rows[i].rd);
            check(32'(resp), 32'(rows[i].rs));
        end
        measure(pers[0]);
        bus_wr(i_ct, 8'h05, 4'h1);
        wait_rise(1'b0);
        t0 = cyc;
        bus_wr(i_ct, 8'h05, 4'h1);
        clk_en <= 1'b0;
        repeat (10) @(posedge clk);
        clk_en <= 1'b1;
        wait_rise(1'b0);
        check(32'(cyc - t0), 32'h00000032);
        foreach (pers[i]) measure(pers[i]);
        bus_wr(i_ct, 8'h00, 4'h1);
        bus_wr(i_mh, 8'h03, 4'h1);
        bus_wr(i_ct, 8'h24, 4'h1);
        repeat (60) @(posedge clk);
        check(32'(irq_h), 32'h0);
        bus_wr(i_ct, 8'h00, 4'h1);
        bus_wr(i_dm, 8'h20, 4'h1);
        bus_wr(i_ml, 8'hFF, 4'h1);
        bus_wr(i_mh, 8'hFF, 4'h1);
        bus_wr(i_ct, 8'h04, 4'h1);
        bus_wr(i_ct, 8'h44, 4'h1);
        bus_wr(i_dm, 8'hA0, 4'h1);
        bus_rd(i_ml);
        check(rd, 32'h00000003);
        bus_rd(i_mh);
        check(rd, 32'h0);
        bus_wr(i_dm, 8'h20, 4'h1);
        bus_rd(i_ml);
        check(rd, 32'h000000FF);
        do_reset();
        check(32'({irq_l, irq_h}), 32'h0);
        for (int k = 0; k < 4; k++) begin
            bus_rd(i_ml + 16'(k));
            check(rd, 32'h0);
        end
        end_sim();
    end

    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule
